// File: include/vat_pkg.sv
// Behaviour
// - translate only when status word bit set
// - fetch and operand addresses both translated
// - translation off: address used as real
// - channel list addresses never translated
// - real-address and purge only compatibility mode
// - three instructions privileged, mode independent
// - segment size from control zero bits 11,12
// - page size from control zero bits 8,9
// - full 16-megabyte virtual space always
// - real storage contiguous from address zero
// - real address converted through directory
// - program sections scattered, not from zero
// - virtual address split segment/page/byte
// - segment length from control one, top byte
// - invalid entry raises translation exception
package vat_pkg;
	localparam int VA_W      = 24;
	localparam int FRAME_W   = 13;          // 2 KiB frames in a 24-bit space
	localparam int DIR_DEPTH = 512;         // directory entries held in flip-flops
	localparam int DIR_IDX_W = 9;
	// register byte addresses
	localparam logic [5:0] OFS_CTRL  = 6'h00;
	localparam logic [5:0] OFS_CR0   = 6'h04;
	localparam logic [5:0] OFS_CR1   = 6'h08;
	localparam logic [5:0] OFS_STAT  = 6'h0c;
	localparam logic [5:0] OFS_CLR   = 6'h10;
	localparam logic [5:0] OFS_IEN   = 6'h14;
	localparam logic [5:0] OFS_DIRA  = 6'h18;
	localparam logic [5:0] OFS_DIRD  = 6'h1c;
	localparam logic [5:0] OFS_ENTRY = 6'h20;
	localparam logic [5:0] OFS_RESLT = 6'h24;
	// control fields
	localparam int CTRL_XLATE = 0;
	localparam int CTRL_EXT   = 1;
	localparam int CTRL_COMPAT= 2;
	localparam int CTRL_PROB  = 3;
	// control register zero field positions (bit 0 = msb of 32)
	localparam int CR0_PG_HI  = 31 - 8;
	localparam int CR0_PG_LO  = 31 - 9;
	localparam int CR0_SG_HI  = 31 - 11;
	localparam int CR0_SG_LO  = 31 - 12;
	localparam logic [1:0] SEG_64K = 2'b00;
	localparam logic [1:0] SEG_1M  = 2'b10;
	localparam logic [1:0] PG_2K   = 2'b01;
	localparam logic [1:0] PG_4K   = 2'b10;
	// status bits
	localparam int ST_XLATE   = 0;
	localparam int ST_LENGTH  = 1;
	localparam int ST_PRIV    = 2;
	localparam int ST_OPER    = 3;
	localparam int ST_SPEC    = 4;
	localparam int ST_W       = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0004;
	localparam logic [31:0] CR0_RST  = 32'h0080_0000;
	localparam logic [31:0] CR1_RST  = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED = 32'h0000_0000;
	// request kinds
	typedef enum logic [2:0] {
		VAT_FETCH, VAT_OPERAND, VAT_CHANNEL, VAT_LRA, VAT_RRB, VAT_PURGE
	} vat_kind_e;
endpackage : vat_pkg

// File: src/vat_split.sv
`timescale 1ns/1ps
`default_nettype none
module vat_split
	import vat_pkg::*;
(
	// address and sizes
	input  wire logic [VA_W-1:0] vaddr,
	input  wire logic [1:0]      seg_code,
	input  wire logic [1:0]      pg_code,
	// fields
	output logic [7:0]           seg_idx,
	output logic [8:0]           page_idx,
	output logic [11:0]          byte_off,
	output logic                 bad_code
);
	// field cut depends on both sizes; 24 bits always decoded
	always_comb
	begin
		seg_idx  = (seg_code == SEG_1M) ? {4'h0, vaddr[23:20]} : vaddr[23:16];
		byte_off = (pg_code == PG_4K) ? vaddr[11:0] : {1'b0, vaddr[10:0]};
		unique case ({seg_code == SEG_1M, pg_code == PG_4K})
			2'b11: page_idx = {1'b0, vaddr[19:12]};
			2'b10: page_idx = vaddr[19:11];
			2'b01: page_idx = {5'h00, vaddr[15:12]};
			2'b00: page_idx = {4'h0, vaddr[15:11]};
		endcase
		bad_code = !(seg_code == SEG_64K || seg_code == SEG_1M)
			|| !(pg_code == PG_2K || pg_code == PG_4K);
	end
endmodule : vat_split
`default_nettype wire

// File: src/vat_top.sv
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vat_top
	import vat_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// avalon-mm slave
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// core request
	input  wire logic        REQ_VALID,
	input  wire logic [2:0]  REQ_KIND,
	input  wire logic [23:0] REQ_ADDR,
	// answer
	output logic             RSP_VALID,
	output logic [23:0]      RSP_PADDR,
	output logic             RSP_EXCEPT,
	output logic             PURGE_PULSE,
	output logic             IRQ
);
	// software registers
	logic [31:0] ctrl_reg, cr0_reg, cr1_reg, entry_reg, result_reg;
	logic [ST_W-1:0] stat_reg, ien_reg;
	logic [DIR_IDX_W-1:0] dira_reg;
	logic [FRAME_W-1:0] dir_mem [DIR_DEPTH];
	logic ack_reg;
	logic [7:0] seg_idx;
	logic [8:0] page_idx;
	logic [11:0] byte_off;
	logic bad_code;
	logic xlate_on, privileged, compat, rd_hit, wr_hit;
	logic [ST_W-1:0] ev;
	logic [23:0] real_addr;
	logic [23:0] raw_paddr;
	logic [FRAME_W-1:0] frame_hi;
	logic [31:0] seg_len;
	vat_kind_e kind;

	vat_split u_split (
		.vaddr    (REQ_ADDR),
		.seg_code (cr0_reg[CR0_SG_HI:CR0_SG_LO]),
		.pg_code  (cr0_reg[CR0_PG_HI:CR0_PG_LO]),
		.seg_idx  (seg_idx),
		.page_idx (page_idx),
		.byte_off (byte_off),
		.bad_code (bad_code)
	);

	// directory lookup maps a contiguous real space onto scattered sections
	function automatic logic [23:0] to_proc(input logic [23:0] ra,
		input logic [FRAME_W-1:0] fr);
		to_proc = {fr, ra[10:0]};
	endfunction : to_proc

	assign kind = vat_kind_e'(REQ_KIND);
	assign compat = ctrl_reg[CTRL_COMPAT];
	assign privileged = kind inside {VAT_LRA, VAT_RRB, VAT_PURGE};
	// translation only with status-word bit, extended mode and compat arch
	assign xlate_on = compat && ctrl_reg[CTRL_EXT] && ctrl_reg[CTRL_XLATE];
	assign seg_len = {24'h0, cr1_reg[31:24]};
	// untranslated path built straight from the request, so the checks do not share real_addr
	assign raw_paddr = {dir_mem[REQ_ADDR[DIR_IDX_W+10:11]], REQ_ADDR[10:0]};

	// real address: page frame from entry, or raw address when off
	always_comb
	begin
		real_addr = REQ_ADDR;
		if (xlate_on && kind != VAT_CHANNEL)
		begin
			if (cr0_reg[CR0_PG_HI:CR0_PG_LO] == PG_4K)
				real_addr = {entry_reg[11:0], byte_off};
			else
				real_addr = {entry_reg[12:0], byte_off[10:0]};
		end
		// directory holds DIR_DEPTH frames; higher real frames alias onto it
		frame_hi = dir_mem[real_addr[DIR_IDX_W+10:11]];
	end

	// event detection for one request
	always_comb
	begin
		ev = '0;
		if (REQ_VALID)
		begin
			if (privileged && ctrl_reg[CTRL_PROB])
				ev[ST_PRIV] = 1'b1;
			else if ((kind == VAT_LRA || kind == VAT_PURGE) && !compat)
				ev[ST_OPER] = 1'b1;
			else if (xlate_on && kind != VAT_CHANNEL && kind != VAT_PURGE)
			begin
				if (bad_code)
					ev[ST_SPEC] = 1'b1;
				else if ({24'h0, seg_idx} > seg_len)
					ev[ST_LENGTH] = 1'b1;
				else if (entry_reg[31])
					ev[ST_XLATE] = 1'b1;
			end
		end
	end

	// answer pipeline: one cycle after the request
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			RSP_VALID <= 1'b0;
			RSP_PADDR <= 24'h00_0000;
			RSP_EXCEPT <= 1'b0;
			PURGE_PULSE <= 1'b0;
		end
		else
		begin
			RSP_VALID <= REQ_VALID;
			RSP_EXCEPT <= |ev;
			RSP_PADDR <= (|ev) ? 24'h00_0000 : to_proc(real_addr, frame_hi);
			PURGE_PULSE <= REQ_VALID && kind == VAT_PURGE && ~|ev;
		end
	end

	// translation result for software inspection (load real address)
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			result_reg <= 32'h0000_0000;
		else if (REQ_VALID && kind == VAT_LRA && ~|ev)
			result_reg <= {8'h00, real_addr};
	end

	assign rd_hit = AVS_READ && AVS_WAITREQUEST;
	assign wr_hit = AVS_WRITE && AVS_WAITREQUEST;

	// bus handshake: one wait cycle then release
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			ack_reg <= 1'b0;
		else
			ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
	end
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			AVS_WAITREQUEST <= 1'b1;
		else
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_reg);
	end

	// control registers written at the edge where waitrequest is low
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= CTRL_RST;
			cr0_reg <= CR0_RST;
			cr1_reg <= CR1_RST;
			ien_reg <= '0;
			dira_reg <= '0;
			entry_reg <= 32'h0000_0000;
		end
		else if (AVS_WRITE && !AVS_WAITREQUEST)
		begin
			unique case (AVS_ADDRESS)
				OFS_CTRL:  ctrl_reg <= AVS_WRITEDATA;
				OFS_CR0:   cr0_reg <= AVS_WRITEDATA;
				OFS_CR1:   cr1_reg <= AVS_WRITEDATA;
				OFS_IEN:   ien_reg <= AVS_WRITEDATA[ST_W-1:0];
				OFS_DIRA:  dira_reg <= AVS_WRITEDATA[DIR_IDX_W-1:0];
				OFS_ENTRY: entry_reg <= AVS_WRITEDATA;
				default: ;
			endcase
		end
	end

	// directory storage, indexed by frame number
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < DIR_DEPTH; i++)
				dir_mem[i] <= FRAME_W'(i);
		end
		else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_DIRD)
			dir_mem[dira_reg] <= AVS_WRITEDATA[FRAME_W-1:0];
	end

	// sticky status: set wins over a simultaneous clear
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
			stat_reg <= '0;
		else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CLR)
			stat_reg <= (stat_reg & ~AVS_WRITEDATA[ST_W-1:0]) | ev;
		else
			stat_reg <= stat_reg | ev;
	end

	// read data and interrupt
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			AVS_READDATA <= 32'h0000_0000;
			IRQ <= 1'b0;
		end
		else
		begin
			IRQ <= |(stat_reg & ien_reg);
			if (rd_hit)
			begin
				unique case (AVS_ADDRESS)
					OFS_CTRL:  AVS_READDATA <= ctrl_reg;
					OFS_CR0:   AVS_READDATA <= cr0_reg;
					OFS_CR1:   AVS_READDATA <= cr1_reg;
					OFS_STAT:  AVS_READDATA <= {27'h0, stat_reg};
					OFS_IEN:   AVS_READDATA <= {27'h0, ien_reg};
					OFS_DIRA:  AVS_READDATA <= {23'h0, dira_reg};
					OFS_DIRD:  AVS_READDATA <= {19'h0, dir_mem[dira_reg]};
					OFS_ENTRY: AVS_READDATA <= entry_reg;
					OFS_RESLT: AVS_READDATA <= result_reg;
					default:   AVS_READDATA <= UNMAPPED;
				endcase
			end
		end
	end

	// checks
	a_channel_raw: assert property (@(posedge CLOCK) disable iff (!RST_N)
		REQ_VALID && kind == VAT_CHANNEL && ~|ev |=> RSP_PADDR == $past(raw_paddr))
		else $error("channel address altered");
	a_off_raw: assert property (@(posedge CLOCK) disable iff (!RST_N)
		REQ_VALID && !xlate_on && ~|ev |=> RSP_PADDR == $past(raw_paddr))
		else $error("untranslated address altered");
	a_rsp_timing: assert property (@(posedge CLOCK) disable iff (!RST_N)
		RSP_VALID == $past(REQ_VALID))
		else $error("answer not one cycle after request");
	a_purge_only: assert property (@(posedge CLOCK) disable iff (!RST_N)
		PURGE_PULSE |-> $past(REQ_VALID) && $past(REQ_KIND) == VAT_PURGE)
		else $error("purge pulse without purge request");
	a_priv_block: assert property (@(posedge CLOCK) disable iff (!RST_N)
		REQ_VALID && privileged && ctrl_reg[CTRL_PROB] |=> RSP_EXCEPT && stat_reg[ST_PRIV])
		else $error("privileged op not refused");
	a_invalid_exc: assert property (@(posedge CLOCK) disable iff (!RST_N)
		REQ_VALID && xlate_on && kind == VAT_OPERAND && !bad_code && entry_reg[31]
		|=> RSP_EXCEPT) else $error("invalid entry not flagged");
	a_irq_level: assert property (@(posedge CLOCK) disable iff (!RST_N)
		|(stat_reg & ien_reg) |=> IRQ) else $error("irq missing");
endmodule : vat_top
`default_nettype wire

// File: tb/vat_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vat_core_model
	import vat_pkg::*;
(
	// request side of the core
	input  wire logic  clock,
	output logic        req_valid,
	output logic [2:0]  req_kind,
	output logic [23:0] req_addr
);
	initial
	begin
		req_valid = 1'b0;
		req_kind  = 3'h0;
		req_addr  = 24'h0;
	end
	// one-cycle request; the address is inverted after, so no stale value looks valid
	task automatic issue(input logic [2:0] k, input logic [23:0] a);
		@(posedge clock);
		req_valid <= 1'b1;
		req_kind  <= k;
		req_addr  <= a;
		@(posedge clock);
		req_valid <= 1'b0;
		req_addr  <= ~a;
	endtask : issue
endmodule : vat_core_model
`default_nettype wire

// File: tb/vat_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vat_top_tb
	import vat_pkg::*;
;
	logic        CLOCK, RST_N, AVS_READ, AVS_WRITE, REQ_VALID;
	logic        AVS_WAITREQUEST, RSP_VALID, RSP_EXCEPT, PURGE_PULSE, IRQ;
	logic [5:0]  AVS_ADDRESS;
	logic [2:0]  REQ_KIND;
	logic [23:0] REQ_ADDR, RSP_PADDR;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	int          failures = 0;
	int          n_tests = 0;
	vat_top DUT (.CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND), .REQ_ADDR(REQ_ADDR),
		.RSP_VALID(RSP_VALID), .RSP_PADDR(RSP_PADDR), .RSP_EXCEPT(RSP_EXCEPT),
		.PURGE_PULSE(PURGE_PULSE), .IRQ(IRQ));
	vat_core_model core (.clock(CLOCK), .req_valid(REQ_VALID), .req_kind(REQ_KIND),
		.req_addr(REQ_ADDR));
	// 200 MHz clock
	initial
	begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// bus cycle: held until waitrequest is seen low at an edge
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE     <= w;
		AVS_READ      <= !w;
		// no cycle limit here: only the watchdog ends a stuck wait
		do
			@(posedge CLOCK);
		while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ  <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask : acc
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rchk
	// answer comes exactly one edge after the request
	task automatic xchk(input logic [2:0] k, input logic [23:0] a, input logic x);
		core.issue(k, a);
		#1;
		chk({31'h0, RSP_VALID}, 32'h1);
		chk({31'h0, RSP_EXCEPT}, {31'h0, x});
	endtask : xchk
	task automatic t_off;
		rchk(OFS_CTRL, CTRL_RST);
		rchk(OFS_CR0, CR0_RST);
		rchk(OFS_CR1, CR1_RST);
		rchk(6'h28, UNMAPPED);
		xchk(VAT_FETCH, 24'h023456, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'h023456);
		acc(1'b1, OFS_DIRA, 32'h46);
		acc(1'b1, OFS_DIRD, 32'h1abc);
		xchk(VAT_OPERAND, 24'h023456, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'hd5e456);
		$display("test off done");
	endtask : t_off
	task automatic t_on;
		acc(1'b1, OFS_CR0, 32'h0040_0000);
		acc(1'b1, OFS_ENTRY, 32'h46);
		acc(1'b1, OFS_CTRL, 32'h7);
		xchk(VAT_FETCH, 24'h000055, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'hd5e055);
		xchk(VAT_OPERAND, 24'h000055, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'hd5e055);
		xchk(VAT_LRA, 24'h000055, 1'b0);
		rchk(OFS_RESLT, 32'h0002_3055);
		xchk(VAT_CHANNEL, 24'h023456, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'hd5e456);
		xchk(VAT_FETCH, 24'h020055, 1'b1);
		acc(1'b1, OFS_CR1, 32'h0200_0000);
		xchk(VAT_FETCH, 24'h020055, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'hd5e055);
		$display("test on done");
	endtask : t_on
	task automatic t_size;
		acc(1'b1, OFS_CR0, 32'h0080_0000);
		acc(1'b1, OFS_ENTRY, 32'h023);
		xchk(VAT_FETCH, 24'h000abc, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'h023abc);
		xchk(VAT_FETCH, 24'h0f0abc, 1'b1);
		acc(1'b1, OFS_CR0, 32'h0090_0000);
		acc(1'b1, OFS_CR1, 32'h0);
		xchk(VAT_FETCH, 24'hff0abc, 1'b1);
		xchk(VAT_FETCH, 24'h0f0abc, 1'b0);
		chk({8'h0, RSP_PADDR}, 32'h023abc);
		acc(1'b1, OFS_CR0, 32'h0088_0000);
		xchk(VAT_FETCH, 24'h000abc, 1'b1);
		acc(1'b1, OFS_CR0, 32'h00c0_0000);
		xchk(VAT_FETCH, 24'h000abc, 1'b1);
		acc(1'b1, OFS_CR0, 32'h0090_0000);
		$display("test sizes done");
	endtask : t_size
	task automatic t_irq;
		acc(1'b1, OFS_CLR, 32'h1f);
		acc(1'b1, OFS_IEN, 32'h1);
		acc(1'b1, OFS_ENTRY, 32'h8000_0000);
		xchk(VAT_FETCH, 24'h000abc, 1'b1);
		rchk(OFS_STAT, 32'h1);
		chk({31'h0, IRQ}, 32'h1);
		acc(1'b1, OFS_CLR, 32'h1);
		rchk(OFS_STAT, 32'h0);
		chk({31'h0, IRQ}, 32'h0);
		acc(1'b1, OFS_IEN, 32'h0);
		xchk(VAT_OPERAND, 24'h000abc, 1'b1);
		rchk(OFS_STAT, 32'h1);
		chk({31'h0, IRQ}, 32'h0);
		$display("test interrupt done");
	endtask : t_irq
	task automatic t_priv;
		acc(1'b1, OFS_CTRL, 32'hf);
		for (int k = 3; k < 6; k++)
			xchk(k[2:0], 24'h0, 1'b1);
		acc(1'b1, OFS_CTRL, 32'h6);
		xchk(VAT_PURGE, 24'h0, 1'b0);
		chk({31'h0, PURGE_PULSE}, 32'h1);
		acc(1'b1, OFS_CTRL, 32'h2);
		xchk(VAT_LRA, 24'h0, 1'b1);
		xchk(VAT_PURGE, 24'h0, 1'b1);
		chk({31'h0, PURGE_PULSE}, 32'h0);
		xchk(VAT_RRB, 24'h0, 1'b0);
		acc(1'b1, OFS_CTRL, 32'h4);
		xchk(VAT_LRA, 24'h0, 1'b0);
		rchk(OFS_RESLT, 32'h0);
		rchk(OFS_STAT, 32'hd);
		$display("test privileged done");
	endtask : t_priv
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// watchdog: the sequence needs well under 2000 cycles
	initial
	begin
		#20000;
		failures++;
		close_out();
	end
	initial
	begin
		RST_N = 1'b0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 6'h0;
		AVS_WRITEDATA = 32'h0;
		repeat (4) @(posedge CLOCK);
		RST_N <= 1'b1;
		t_off();
		t_on();
		t_size();
		t_irq();
		t_priv();
		close_out();
	end
endmodule : vat_top_tb
`default_nettype wire
